// >>> common/srp_pkg.sv
// constants for the session request controller and its device port
// assumes a 25 MHz clock and the device's 8-bit register port
// Functional notes
// - data-line pulse bit 5, default 0, cleared after
// - flag 0 means failed; restart, disable or handle
// - flag 1: clear enable, then set pull-up
// - wait up to 5 s for host response
// - clear init-condition bit 3, wait >2 ms, read
// - init-condition 0 starts request, 1 aborts it
// - bit 2 discharges VBUS, 30 ms, clear after
// - VBUS pulse bit 1 held 16 to 26 ms
// - finish both pulses before checking session-valid
// - optional discharge after pulses, before flag clear
// - data-line pulse lasts 5 to 10 ms
// - both pulses done within 100 ms
package srp_pkg;
    // device register addresses
    localparam logic [7:0] SRC_ADDR      = 8'h12;
    localparam logic [7:0] MODE_REG_ADDR = 8'h0C;
    // field positions in the session request register, plus the pull-up bit of the mode register
    localparam int EN_BIT  = 0;
    localparam int VPL_BIT = 1;
    localparam int DIS_BIT = 2;
    localparam int IC_BIT  = 3;
    localparam int SV_BIT  = 4;
    localparam int DLP_BIT = 5;
    localparam int PULLUP_BIT = 0;
    // single-bit masks derived from the positions
    localparam logic [7:0] M_EN  = 8'h01 << EN_BIT;
    localparam logic [7:0] M_VPL = 8'h01 << VPL_BIT;
    localparam logic [7:0] M_DIS = 8'h01 << DIS_BIT;
    localparam logic [7:0] M_IC  = 8'h01 << IC_BIT;
    localparam logic [7:0] M_SV  = 8'h01 << SV_BIT;
    localparam logic [7:0] M_DLP = 8'h01 << DLP_BIT;
    localparam logic [7:0] M_PU  = 8'h01 << PULLUP_BIT;
    // timing, in microseconds, with the clock in MHz and the timer width in bits
    localparam int CLK_MHZ      = 25;
    localparam int INIT_WAIT_US = 2000;
    localparam int DISCH_US     = 30000;
    localparam int DLP_US       = 7500;
    localparam int VPL_US       = 21000;
    localparam int SV_WAIT_US   = 5000000;
    localparam int POLL_US      = 1000;
    localparam int TMR_W        = 27;
    // device port strobe and read sync lengths
    localparam int DEV_STB_CYC  = 4;
    localparam int DEV_SYNC_CYC = 2;
    // apb register offsets and reset values
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] LAST_OFS = 12'h008;
    localparam logic [31:0] ZERO32   = 32'h0000_0000;
    // sequencer states
    typedef enum logic [4:0] {
        S_IDLE      = 5'b00000,
        S_EN        = 5'b00001,
        S_IC_CLR    = 5'b00010,
        S_IC_WAIT   = 5'b00011,
        S_IC_READ   = 5'b00100,
        S_DIS_ON    = 5'b00101,
        S_DIS_WAIT  = 5'b00110,
        S_DIS_OFF   = 5'b00111,
        S_DLP_ON    = 5'b01000,
        S_DLP_WAIT  = 5'b01001,
        S_DLP_OFF   = 5'b01010,
        S_VPL_WAIT  = 5'b01011,
        S_VPL_OFF   = 5'b01100,
        S_SV_CLR    = 5'b01101,
        S_POLL_WAIT = 5'b01110,
        S_POLL_READ = 5'b01111,
        S_OFF       = 5'b10000,
        S_MODE_RD   = 5'b10001,
        S_MODE_WR   = 5'b10010
    } state_e;
endpackage

// >>> common/dev_reg_if.sv
// one register access request between sequencer and device port
// assumes both ends share one clock
`timescale 1ns/1ps
interface dev_reg_if;
    logic       req;   // one-cycle request
    logic       wr;    // 1 write, 0 read
    logic [7:0] addr;  // device register address
    logic [7:0] wdata; // write byte
    logic [7:0] rdata; // read byte, valid with done
    logic       done;  // one-cycle completion
    modport master (output req, wr, addr, wdata, input rdata, done);
    modport access (input req, wr, addr, wdata, output rdata, done);
endinterface

// >>> verilog/dev_reg_access.sv
// drives one device register cycle on the device pins
// assumes read data from the device is asynchronous to clock
`timescale 1ns/1ps
module dev_reg_access import srp_pkg::*; (
    input  wire logic       clock,
    input  wire logic       rstn,
    dev_reg_if.access       bus,
    output logic [7:0]      devAddr,
    output logic [7:0]      devWrData,
    input  wire logic [7:0] devRdData,
    output logic            devWrStb,
    output logic            devRdStb
);
    localparam logic [2:0] STB_LAST = 3'(DEV_STB_CYC - 1);
    localparam logic [2:0] ACC_LAST = 3'(DEV_STB_CYC + DEV_SYNC_CYC - 1);
    logic [7:0] rdS1_ff;   // first sync stage
    logic [7:0] rdS2_ff;   // second sync stage
    logic [7:0] addr_ff;   // held address
    logic [7:0] wdata_ff;  // held write byte
    logic [7:0] rdata_ff;  // captured read byte
    logic [2:0] cnt_ff;    // cycle in access
    logic       busy_ff;   // access running
    logic       wr_ff;     // direction
    logic       stb_ff;    // strobe active
    logic       done_ff;   // completion pulse
    wire logic  start   = bus.req & ~busy_ff;
    wire logic  lastCyc = busy_ff & (cnt_ff == ACC_LAST);
    // read data synchroniser
    always_ff @(posedge clock) begin
        rdS1_ff <= devRdData;
        rdS2_ff <= rdS1_ff;
    end
    // access sequencing
    always_ff @(posedge clock) begin
        if (!rstn) begin
            busy_ff  <= 1'b0;
            stb_ff   <= 1'b0;
            done_ff  <= 1'b0;
            wr_ff    <= 1'b0;
            cnt_ff   <= 3'h0;
            addr_ff  <= 8'h00;
            wdata_ff <= 8'h00;
            rdata_ff <= 8'h00;
        end else begin
            done_ff <= lastCyc;
            if (start) begin
                busy_ff  <= 1'b1;
                stb_ff   <= 1'b1;
                cnt_ff   <= 3'h0;
                wr_ff    <= bus.wr;
                addr_ff  <= bus.addr;
                wdata_ff <= bus.wdata;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff + 3'h1;
                if (cnt_ff == STB_LAST) stb_ff <= 1'b0;
                if (lastCyc) begin
                    busy_ff  <= 1'b0;
                    rdata_ff <= rdS2_ff;
                end
            end
        end
    end
    assign devAddr   = addr_ff;
    assign devWrData = wdata_ff;
    assign devWrStb  = stb_ff & wr_ff;
    assign devRdStb  = stb_ff & ~wr_ff;
    assign bus.rdata = rdata_ff;
    assign bus.done  = done_ff;
endmodule

// >>> verilog/session_request_ctrl.sv
// host sequencer that runs a session request on the usb device
// assumes apb from software and the device's 8-bit register port
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module session_request_ctrl import srp_pkg::*; #(
    parameter int INIT_CYC  = INIT_WAIT_US * CLK_MHZ + 1,
    parameter int DISCH_CYC = DISCH_US * CLK_MHZ,
    parameter int DLP_CYC   = DLP_US * CLK_MHZ,
    parameter int VPL_CYC   = VPL_US * CLK_MHZ,
    parameter int SV_CYC    = SV_WAIT_US * CLK_MHZ,
    parameter int POLL_CYC  = POLL_US * CLK_MHZ
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [7:0]       devAddr,
    output logic [7:0]       devWrData,
    input  wire logic [7:0]  devRdData,
    output logic             devWrStb,
    output logic             devRdStb
);
    // sequencer state
    state_e            state_ff;    // current step
    state_e            nxt_state;   // next step
    logic              issued_ff;   // device access pending
    logic [TMR_W-1:0]  tmr_ff;      // step timer
    logic [TMR_W-1:0]  tmo_ff;      // host response timer
    logic              post_ff;     // discharge after pulses
    // software view
    logic              cfgPre_ff;   // discharge before request
    logic              cfgPost_ff;  // discharge after pulses
    logic              doneF_ff;    // sequence finished
    logic              okF_ff;      // session became valid
    logic              icF_ff;      // initial condition failed
    logic              tmoF_ff;     // host gave no response
    logic              abtF_ff;     // aborted by software
    logic [7:0]        last_ff;     // last byte read from device
    logic [31:0]       prdata_ff;   // read data for apb
    logic              pslverr_ff;  // unmapped access

    dev_reg_if devBus ();

    // device pin cycles
    dev_reg_access u_access (
        .clock     (clock),
        .rstn      (rstn),
        .bus       (devBus),
        .devAddr   (devAddr),
        .devWrData (devWrData),
        .devRdData (devRdData),
        .devWrStb  (devWrStb),
        .devRdStb  (devRdStb)
    );

    // apb decode
    wire logic apbSetup = psel & ~penable;
    wire logic apbAcc   = psel & penable;
    wire logic apbWr    = apbAcc & pwrite;
    wire logic hitCtrl  = (paddr == CTRL_OFS);
    wire logic hitStat  = (paddr == STAT_OFS);
    wire logic hitLast  = (paddr == LAST_OFS);
    wire logic hitAny   = hitCtrl | hitStat | hitLast;
    wire logic idle     = (state_ff == S_IDLE);
    wire logic startCmd = apbWr & hitCtrl & pwdata[0] & idle;
    wire logic abortCmd = apbWr & hitCtrl & pwdata[3] & ~idle;

    // device access handshake
    wire logic opDone   = devBus.done;
    wire logic [7:0] rd = devBus.rdata;
    wire logic isRead   = (state_ff == S_IC_READ) | (state_ff == S_POLL_READ)
                        | (state_ff == S_MODE_RD);
    wire logic isWait   = (state_ff == S_IC_WAIT) | (state_ff == S_DIS_WAIT)
                        | (state_ff == S_DLP_WAIT) | (state_ff == S_VPL_WAIT)
                        | (state_ff == S_POLL_WAIT);
    wire logic isOp     = ~idle & ~isWait;
    wire logic inPoll   = (state_ff == S_POLL_WAIT) | (state_ff == S_POLL_READ);

    assign devBus.req  = isOp & ~issued_ff;
    assign devBus.wr   = ~isRead;
    assign devBus.addr = (state_ff == S_MODE_RD || state_ff == S_MODE_WR)
                       ? MODE_REG_ADDR : SRC_ADDR;

    // byte written by each step
    logic [7:0] opData;
    always_comb begin
        case (state_ff)
            S_EN:      opData = M_EN;
            S_IC_CLR:  opData = M_EN | M_IC;
            S_DIS_ON:  opData = M_EN | M_DIS;
            S_DIS_OFF: opData = M_EN;
            S_DLP_ON:  opData = M_EN | M_DLP;
            S_DLP_OFF: opData = M_EN | M_VPL;
            S_VPL_OFF: opData = M_EN;
            S_SV_CLR:  opData = M_EN | M_SV;
            S_MODE_WR: opData = last_ff | M_PU;
            default:   opData = 8'h00;
        endcase
    end
    assign devBus.wdata = opData;

    // step time limit for wait states
    logic [TMR_W-1:0] lim;
    always_comb begin
        case (state_ff)
            S_IC_WAIT:  lim = TMR_W'(INIT_CYC - 1);
            S_DIS_WAIT: lim = TMR_W'(DISCH_CYC - 1);
            S_DLP_WAIT: lim = TMR_W'(DLP_CYC - 1);
            S_VPL_WAIT: lim = TMR_W'(VPL_CYC - 1);
            default:    lim = TMR_W'(POLL_CYC - 1);
        endcase
    end
    wire logic tmrHit  = (tmr_ff == lim);
    wire logic timeout = (tmo_ff >= TMR_W'(SV_CYC - 1));

    // step order
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE:
                if (startCmd) nxt_state = S_EN;
            S_EN:
                if (opDone) nxt_state = S_IC_CLR;
            S_IC_CLR:
                if (opDone) nxt_state = S_IC_WAIT;
            S_IC_WAIT:
                if (abortCmd) nxt_state = S_OFF;
                else if (tmrHit) nxt_state = S_IC_READ;
            S_IC_READ:
                if (opDone) begin
                    if (rd[IC_BIT]) nxt_state = S_OFF;
                    else if (cfgPre_ff) nxt_state = S_DIS_ON;
                    else nxt_state = S_DLP_ON;
                end
            S_DIS_ON:
                if (opDone) nxt_state = S_DIS_WAIT;
            S_DIS_WAIT:
                if (abortCmd) nxt_state = S_OFF;
                else if (tmrHit) nxt_state = S_DIS_OFF;
            S_DIS_OFF:
                if (opDone) nxt_state = post_ff ? S_SV_CLR : S_DLP_ON;
            S_DLP_ON:
                if (opDone) nxt_state = S_DLP_WAIT;
            S_DLP_WAIT:
                if (tmrHit) nxt_state = S_DLP_OFF;
            S_DLP_OFF:
                if (opDone) nxt_state = S_VPL_WAIT;
            S_VPL_WAIT:
                if (tmrHit) nxt_state = S_VPL_OFF;
            S_VPL_OFF:
                if (opDone) nxt_state = cfgPost_ff ? S_DIS_ON : S_SV_CLR;
            S_SV_CLR:
                if (opDone) nxt_state = S_POLL_WAIT;
            S_POLL_WAIT:
                if (abortCmd || timeout) nxt_state = S_OFF;
                else if (tmrHit) nxt_state = S_POLL_READ;
            S_POLL_READ:
                if (opDone) begin
                    if (rd[SV_BIT] || timeout) nxt_state = S_OFF;
                    else nxt_state = S_POLL_WAIT;
                end
            S_OFF:
                if (opDone) nxt_state = okF_ff ? S_MODE_RD : S_IDLE;
            S_MODE_RD:
                if (opDone) nxt_state = S_MODE_WR;
            S_MODE_WR:
                if (opDone) nxt_state = S_IDLE;
            default:
                nxt_state = S_IDLE;
        endcase
    end

    // outcome events
    wire logic evIc   = (state_ff == S_IC_READ) & opDone & rd[IC_BIT];
    wire logic evOk   = (state_ff == S_POLL_READ) & opDone & rd[SV_BIT];
    wire logic evTmo  = inPoll & timeout & ~evOk & (nxt_state == S_OFF);
    wire logic evDone = ~idle & (nxt_state == S_IDLE);
    wire logic evAbt  = abortCmd & isWait & (nxt_state == S_OFF);
    wire logic stepChg = (nxt_state != state_ff);

    // sequencer registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_ff  <= S_IDLE;
            issued_ff <= 1'b0;
            tmr_ff    <= '0;
            tmo_ff    <= '0;
            post_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // pending flag drops with completion
            if (opDone) issued_ff <= 1'b0;
            else if (devBus.req) issued_ff <= 1'b1;
            // step timer restarts on every change
            tmr_ff <= (stepChg || !isWait) ? '0 : tmr_ff + 1'b1;
            // response timer spans the whole poll phase
            tmo_ff <= inPoll ? tmo_ff + 1'b1 : '0;
            if (startCmd) post_ff <= 1'b0;
            else if (state_ff == S_VPL_OFF && nxt_state == S_DIS_ON) post_ff <= 1'b1;
        end
    end

    // software configuration and result flags
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cfgPre_ff  <= 1'b0;
            cfgPost_ff <= 1'b0;
            doneF_ff   <= 1'b0;
            okF_ff     <= 1'b0;
            icF_ff     <= 1'b0;
            tmoF_ff    <= 1'b0;
            abtF_ff    <= 1'b0;
            last_ff    <= 8'h00;
        end else begin
            if (apbWr && hitCtrl && idle) begin
                cfgPre_ff  <= pwdata[1];
                cfgPost_ff <= pwdata[2];
            end
            // a new request clears old results
            doneF_ff <= startCmd ? 1'b0 : (doneF_ff | evDone);
            okF_ff   <= startCmd ? 1'b0 : (okF_ff | evOk);
            icF_ff   <= startCmd ? 1'b0 : (icF_ff | evIc);
            tmoF_ff  <= startCmd ? 1'b0 : (tmoF_ff | evTmo);
            abtF_ff  <= startCmd ? 1'b0 : (abtF_ff | evAbt);
            if (opDone && isRead) last_ff <= rd;
        end
    end

    // register read mux
    wire logic [31:0] ctrlView = {29'h0, cfgPost_ff, cfgPre_ff, 1'b0};
    // outcome is polled here, no interrupt line exists
    wire logic [31:0] statView = {19'h0, state_ff, 2'h0, abtF_ff, tmoF_ff,
                                  icF_ff, okF_ff, doneF_ff, ~idle};
    wire logic [31:0] lastView = {24'h0, last_ff};
    wire logic [31:0] rdMux    = hitCtrl ? ctrlView
                               : hitStat ? statView
                               : hitLast ? lastView : ZERO32;

    // apb answer, zero wait states
    always_ff @(posedge clock) begin
        if (!rstn) begin
            prdata_ff  <= ZERO32;
            pslverr_ff <= 1'b0;
        end else if (apbSetup) begin
            prdata_ff  <= pwrite ? ZERO32 : rdMux;
            pslverr_ff <= ~hitAny;
        end
    end
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff & apbAcc;
    assign pready  = 1'b1;
endmodule

// >>> testbench/session_request_props.sv
// checker for the session request controller's apb and device port pins
// assumes binding into session_request_ctrl with its pulse count parameters
`timescale 1ns/1ps
module session_request_props import srp_pkg::*; #(
    parameter int DLP_CYC = 16,
    parameter int VPL_CYC = 24
) (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  devAddr,
    input wire logic [7:0]  devWrData,
    input wire logic        devWrStb,
    input wire logic        devRdStb
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic wPrev_ff; // write strobe last cycle
    logic enSh_ff;  // enable bit last written
    logic dlpSh_ff; // data-line pulse bit last written
    logic vplSh_ff; // vbus pulse bit last written
    int   gap_ff;   // cycles since last session request register write
    wire  srcWr  = devWrStb && !wPrev_ff && devAddr == SRC_ADDR;
    wire  modeWr = devWrStb && !wPrev_ff && devAddr == MODE_REG_ADDR;
    wire  badAdr = paddr != CTRL_OFS && paddr != STAT_OFS && paddr != LAST_OFS;
    // shadow of what the controller last wrote into the session request register
    always_ff @(posedge clock) begin
        wPrev_ff <= rstn && devWrStb;
        gap_ff   <= (srcWr || !rstn) ? 0 : gap_ff + 1;
        if (!rstn || srcWr) begin
            enSh_ff <= rstn && devWrData[EN_BIT];
            dlpSh_ff <= rstn && devWrData[DLP_BIT];
            vplSh_ff <= rstn && devWrData[VPL_BIT];
        end
    end
    a_wr_strobe_len: assert property ($rose(devWrStb) |-> devWrStb[*4] ##1 !devWrStb)
        else $error("write strobe length wrong");
    a_rd_strobe_len: assert property ($rose(devRdStb) |-> devRdStb[*4] ##1 !devRdStb)
        else $error("read strobe length wrong");
    a_port_gap: assert property (($fell(devWrStb) || $fell(devRdStb)) |-> !devWrStb && !devRdStb)
        else $error("device accesses without idle cycle");
    a_port_hold: assert property ((devWrStb || devRdStb) && $past(devWrStb || devRdStb)
        |-> $stable(devAddr) && $stable(devWrData)) else $error("device address moved");
    a_apb_ready: assert property (psel |-> pready) else $error("pready low");
    a_apb_error: assert property (psel && penable |-> pslverr == badAdr)
        else $error("pslverr wrong for address");
    a_rsvd_zero: assert property (srcWr |-> devWrData[7:6] == 2'b00)
        else $error("reserved bits written nonzero");
    a_pulse_apart: assert property (srcWr && devWrData[DLP_BIT] |-> !devWrData[VPL_BIT])
        else $error("both pulses on at once");
    a_dlp_length: assert property (srcWr && dlpSh_ff && !devWrData[DLP_BIT]
        |-> gap_ff >= DLP_CYC && gap_ff <= DLP_CYC + 20) else $error("data pulse length");
    a_vpl_length: assert property (srcWr && vplSh_ff && !devWrData[VPL_BIT]
        |-> gap_ff >= VPL_CYC && gap_ff <= VPL_CYC + 20) else $error("vbus pulse length");
    a_off_clean: assert property (srcWr && !devWrData[EN_BIT] |-> devWrData[5:0] == 6'h00)
        else $error("controls left on when disabling");
    a_pullup_late: assert property (modeWr |-> !enSh_ff)
        else $error("pull-up set while request enabled");
endmodule

bind session_request_ctrl session_request_props #(.DLP_CYC(DLP_CYC), .VPL_CYC(VPL_CYC)) uProps (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .devAddr(devAddr), .devWrData(devWrData),
    .devWrStb(devWrStb), .devRdStb(devRdStb));

// >>> testbench/srp_device_model.sv
// model of the usb device's register port with the session request register
// assumes strobes last several cycles and never overlap
`timescale 1ns/1ps
module srp_device_model import srp_pkg::*; (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [7:0] devAddr,
    input  wire logic [7:0] devWrData,
    input  wire logic       devWrStb,
    input  wire logic       devRdStb,
    input  wire logic       vbusValid,
    input  wire logic       condBad,
    output logic [7:0]      devRdData,
    output logic            pullupOn
);
    logic [7:0] ctl_ff;   // pulse, discharge and enable controls
    logic       sv_ff;    // latched session-valid flag
    logic       ic_ff;    // latched initial-condition flag
    logic       pu_ff;    // pull-up connect in the mode register
    logic       wPrev_ff; // write strobe last cycle
    logic [1:0] hold_ff;  // read data hold after strobe
    logic [7:0] last_ff;  // last byte driven
    wire        wrEv   = devWrStb && !wPrev_ff;
    wire        srcWr  = wrEv && devAddr == SRC_ADDR;
    wire [7:0]  srcVal = {2'b00, ctl_ff[DLP_BIT], sv_ff, ic_ff, ctl_ff[2:0]};
    wire [7:0]  rdVal  = (devAddr == SRC_ADDR) ? srcVal : {7'h00, pu_ff};
    assign pullupOn = pu_ff;
    // released bus shows the inverse byte so a late capture is caught
    assign devRdData = (devRdStb || hold_ff != 2'd0) ? rdVal : ~last_ff;
    // register updates and flag latching
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctl_ff   <= 8'h00;
            sv_ff    <= 1'b0;
            ic_ff    <= 1'b0;
            pu_ff    <= 1'b0;
            wPrev_ff <= 1'b0;
            hold_ff  <= 2'd0;
            last_ff  <= 8'h00;
        end else begin
            wPrev_ff <= devWrStb;
            hold_ff  <= devRdStb ? 2'd2 : (hold_ff != 2'd0 ? hold_ff - 2'd1 : 2'd0);
            if (devRdStb)
                last_ff <= rdVal;
            if (srcWr)
                ctl_ff <= devWrData & 8'h27;
            if (wrEv && devAddr == MODE_REG_ADDR)
                pu_ff <= devWrData[PULLUP_BIT];
            sv_ff <= (ctl_ff[EN_BIT] && vbusValid) || (sv_ff && !(srcWr && devWrData[SV_BIT]));
            ic_ff <= (ctl_ff[EN_BIT] && condBad) || (ic_ff && !(srcWr && devWrData[IC_BIT]));
        end
    end
endmodule

// >>> testbench/session_request_ctrl_test.sv
// bench: apb sequences on the controller against the device model
// assumes package, design, model and checker compiled first
`timescale 1ns/1ps
module session_request_ctrl_test import srp_pkg::*; ;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = ZERO32;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  devAddr;
    logic [7:0]  devWrData;
    logic [7:0]  devRdData;
    logic        devWrStb;
    logic        devRdStb;
    logic        vbusValid = 1'b0; // session valid on the bus
    logic        condBad = 1'b0;   // initial conditions unmet
    logic        pullupOn;         // data-line pull-up attached
    logic [31:0] prd;              // last apb read data
    logic        perr;             // last apb error
    int          fails = 0;
    int          samples_checked = 0;
    int          n;
    // poll interval keeps its full value; response limit sits just above it
    session_request_ctrl #(.INIT_CYC(20), .DISCH_CYC(30), .DLP_CYC(16), .VPL_CYC(24),
        .SV_CYC(30000)) DUT (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .devAddr(devAddr),
        .devWrData(devWrData), .devRdData(devRdData), .devWrStb(devWrStb),
        .devRdStb(devRdStb));
    srp_device_model uDev (.clock(clock), .rstn(rstn), .devAddr(devAddr),
        .devWrData(devWrData), .devWrStb(devWrStb), .devRdStb(devRdStb),
        .vbusValid(vbusValid), .condBad(condBad), .devRdData(devRdData),
        .pullupOn(pullupOn));
    always #20 clock = ~clock;
    // one apb transfer, holds the request until pready
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 100);
        prd  = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, ZERO32);
        chk(prd, exp);
        chk({31'h0, perr}, ZERO32);
    endtask
    // start a request and wait for busy to drop
    task automatic run(input logic [31:0] c, input logic [31:0] st, input logic [7:0] l);
        xfer(1'b1, CTRL_OFS, c);
        n = 0;
        do begin
            xfer(1'b0, STAT_OFS, ZERO32);
            n++;
        end while (prd[0] !== 1'b0 && n < 12000);
        rd(STAT_OFS, st);
        rd(LAST_OFS, {24'h0, l});
    endtask
    task automatic tally_and_finish();
        $display("checked %0d wrong %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        rd(CTRL_OFS, ZERO32);
        rd(STAT_OFS, ZERO32);
        rd(LAST_OFS, ZERO32);
        xfer(1'b0, 12'h00C, ZERO32);
        chk({31'h0, perr}, 32'h0000_0001);
        chk(prd, ZERO32);
        condBad <= 1'b1;
        run(32'h0000_0001, 32'h0000_000A, 8'h09);
        condBad <= 1'b0;
        run(32'h0000_0003, 32'h0000_0012, 8'h01);
        chk({31'h0, pullupOn}, ZERO32);
        vbusValid <= 1'b1;
        run(32'h0000_0005, 32'h0000_0006, 8'h00);
        chk({31'h0, pullupOn}, 32'h0000_0001);
        // abort while the initial-condition wait runs
        xfer(1'b1, CTRL_OFS, 32'h0000_0001);
        n = 0;
        do begin
            xfer(1'b1, CTRL_OFS, 32'h0000_0008);
            xfer(1'b0, STAT_OFS, ZERO32);
            n++;
        end while (prd[0] !== 1'b0 && n < 200);
        chk(prd & 32'h0000_0021, 32'h0000_0020);
        // reset in mid-request
        xfer(1'b1, CTRL_OFS, 32'h0000_0001);
        rstn <= 1'b0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        rd(STAT_OFS, ZERO32);
        chk({31'h0, pullupOn}, ZERO32);
        tally_and_finish();
    end
    // watchdog against a hung sequence
    initial begin
        repeat (90000) @(posedge clock);
        fails++;
        tally_and_finish();
    end
endmodule
